// file: iwd_pkg.sv
package iwd_pkg;
    localparam int WORD_W       = 14;
    localparam int FADDR_W      = 7;
    localparam int BITNUM_W     = 3;
    localparam int LIT8_W       = 8;
    localparam int LIT11_W      = 11;
    localparam int QPHASES      = 4;
    localparam int PHASE_W      = 2;
    // field positions
    localparam int POS_FADDR    = 0;
    localparam int POS_DEST     = 7;
    localparam int POS_BITNUM   = 7;
    localparam int POS_CLASS    = 12;
    localparam int POS_BYTEOP   = 8;
    localparam int POS_BITOP    = 10;
    localparam int POS_LITSUB   = 8;
    localparam int POS_JMPSEL   = 11;
    // reset values
    localparam logic [13:0] RST_WORD = 14'h0000;
    localparam logic [1:0]  RST_Q    = 2'h0;

    typedef enum {
        IWD_C_NONE, IWD_C_BYTE, IWD_C_BIT, IWD_C_LIT, IWD_C_CTRL
    } iwd_class_e;

    typedef enum {
        IWD_OP_NOP, IWD_OP_ALU, IWD_OP_MOVWF, IWD_OP_CLR, IWD_OP_SKIPDEC, IWD_OP_BCF, IWD_OP_BSF,
        IWD_OP_BTFSC, IWD_OP_BTFSS, IWD_OP_LITALU, IWD_OP_CALL, IWD_OP_GOTO, IWD_OP_RETURN,
        IWD_OP_RETFIE, IWD_OP_RETLW, IWD_OP_SLEEP, IWD_OP_CLRWDT, IWD_OP_OPTLOAD,
        IWD_OP_TRISLOAD, IWD_OP_RESERVED
    } iwd_op_e;

    typedef struct packed {
        logic        valid;
        logic [3:0]  sub;
        logic [6:0]  faddr;
        logic        to_file;
        logic        to_acc;
        logic [2:0]  bitnum;
        logic [7:0]  bitmask;
        logic [10:0] literal;
        logic        lit_long;
        logic        may_skip;
        logic        pc_change;
        logic        reserved;
        logic        legacy;
    } iwd_dec_s;
endpackage

// file: iwd_field_split.sv
`timescale 1ns/100ps
`default_nettype none
module iwd_field_split
    import iwd_pkg::*;
(
    // instruction in
    input  wire logic [13:0] word,
    // decoded fields out
    output iwd_dec_s         dec,
    output iwd_op_e          op
);
    function automatic logic [7:0] bit_onehot(input logic [2:0] n);
        bit_onehot = 8'h01 << n;
    endfunction

    logic [1:0] cls;
    assign cls = word[POS_CLASS +: 2];

    always_comb begin
        dec          = '0;
        op           = IWD_OP_RESERVED;
        dec.valid    = 1'b1;
        dec.faddr    = word[POS_FADDR +: FADDR_W];
        dec.bitnum   = word[POS_BITNUM +: BITNUM_W];
        dec.bitmask  = bit_onehot(word[POS_BITNUM +: BITNUM_W]);
        dec.literal  = {3'h0, word[0 +: LIT8_W]};
        case (cls)
            2'h0: begin
                dec.sub = word[POS_BYTEOP +: 4];
                dec.to_file = word[POS_DEST];
                dec.to_acc  = ~word[POS_DEST];
                op = IWD_OP_ALU;
                case (word[POS_BYTEOP +: 4])
                    4'h0: begin
                        dec.to_acc  = 1'b0;
                        dec.to_file = word[POS_DEST];
                        if (word[POS_DEST]) begin
                            op = IWD_OP_MOVWF;
                        end else if (word[4:0] == 5'h00) begin
                            op = IWD_OP_NOP; // bits 6:5 ignored
                        end else if (word[6:0] == 7'h08) begin
                            op = IWD_OP_RETURN;
                        end else if (word[6:0] == 7'h09) begin
                            op = IWD_OP_RETFIE;
                        end else if (word[6:0] == 7'h62) begin
                            op = IWD_OP_OPTLOAD;
                        end else if (word[6:0] == 7'h63) begin
                            op = IWD_OP_SLEEP;
                        end else if (word[6:0] == 7'h64) begin
                            op = IWD_OP_CLRWDT;
                        end else if (word[6:3] == 4'hC && word[2:0] >= 3'h5) begin
                            op = IWD_OP_TRISLOAD;
                        end else begin
                            op = IWD_OP_RESERVED;
                        end
                    end
                    4'h1: begin
                        op = IWD_OP_CLR; // clrw ignores bits 6:0
                    end
                    4'hB, 4'hF: begin
                        op = IWD_OP_SKIPDEC;
                    end
                    default: op = IWD_OP_ALU;
                endcase
            end
            2'h1: begin
                dec.sub     = {2'h0, word[POS_BITOP +: 2]};
                dec.to_file = ~word[POS_BITOP + 1];
                case (word[POS_BITOP +: 2])
                    2'h0:    op = IWD_OP_BCF;
                    2'h1:    op = IWD_OP_BSF;
                    2'h2:    op = IWD_OP_BTFSC;
                    default: op = IWD_OP_BTFSS;
                endcase
            end
            2'h2: begin
                dec.literal  = word[0 +: LIT11_W];
                dec.lit_long = 1'b1;
                op = word[POS_JMPSEL] ? IWD_OP_GOTO : IWD_OP_CALL;
            end
            default: begin
                dec.sub    = word[POS_LITSUB +: 4];
                dec.to_acc = 1'b1;
                // x bits of movlw, retlw, addlw, sublw folded
                casez (word[POS_LITSUB +: 4])
                    4'b00??: op = IWD_OP_LITALU;
                    4'b01??: op = IWD_OP_RETLW;
                    4'b1000, 4'b1001, 4'b1010, 4'b110?, 4'b111?: op = IWD_OP_LITALU;
                    default: begin
                        op = IWD_OP_RESERVED;
                        dec.to_acc = 1'b0;
                    end
                endcase
            end
        endcase
        dec.may_skip  = (op == IWD_OP_SKIPDEC) || (op == IWD_OP_BTFSC) || (op == IWD_OP_BTFSS);
        dec.pc_change = (op == IWD_OP_CALL) || (op == IWD_OP_GOTO) || (op == IWD_OP_RETURN) ||
                        (op == IWD_OP_RETFIE) || (op == IWD_OP_RETLW) ||
                        (dec.to_file && dec.faddr == 7'h02 && op != IWD_OP_BTFSC && op != IWD_OP_BTFSS);
        dec.reserved  = (op == IWD_OP_RESERVED);
        dec.legacy    = (op == IWD_OP_OPTLOAD) || (op == IWD_OP_TRISLOAD);
    end
endmodule
`default_nettype wire

// file: iwd_decoder.sv
// Contract
// - each instruction is one 14-bit word: opcode plus operand fields
// - byte ops: dest bit 0 writes accumulator, 1 writes file register
// - file address field spans register addresses 0x00 to 0x7F
// - bit ops: bit number selects one of eight file register bits
// - literal field is eight or eleven bits depending on instruction
// - don't-care bits decode identically; software fills them with zero; the code folds them in op only, while sub and faddr still carry them
// - one instruction cycle per instruction unless skip or pc change
// - skip taken or pc changed: two cycles, second executes as no-op
// - an instruction cycle is exactly four oscillator periods
`timescale 1ns/100ps
`default_nettype none
module iwd_decoder
    import iwd_pkg::*;
#(
    parameter int WIDTH = WORD_W
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // program memory
    input  wire logic [13:0] fetch_word,
    output logic             fetch_strobe,
    output logic             fetch_redirect,
    // execution feedback
    input  wire logic        skip_true,
    // decoded instruction
    output iwd_dec_s         exec_dec,
    output iwd_op_e          exec_op,
    output logic             exec_strobe,
    output logic             exec_flush,
    output logic [1:0]       q_phase
);
    // the field split is fixed to the 14-bit word layout
    if (WIDTH != WORD_W) begin : g_width_chk
        $error("instruction width must be 14");
    end

    logic [1:0]  q;
    logic [13:0] cur_word;
    logic        flush_cyc;
    logic        strobe;
    logic        fetch_s;
    logic        redir;
    iwd_dec_s    dec_r;
    iwd_op_e     op_r;
    logic [1:0]  next_q;
    logic [13:0] next_cur_word;
    logic        next_flush_cyc;
    logic        next_strobe;
    logic        next_fetch_s;
    logic        next_redir;
    iwd_dec_s    next_dec_r;
    iwd_op_e     next_op_r;
    iwd_dec_s    dec_w;
    iwd_op_e     op_w;
    logic        cyc_end;
    logic        two_cyc;

    iwd_field_split u_split (
        .word (cur_word),
        .dec  (dec_w),
        .op   (op_w)
    );

    assign cyc_end = (q == 2'(QPHASES - 1));
    // skip result arrives from execution before the cycle ends
    assign two_cyc = !flush_cyc && (dec_w.pc_change || (dec_w.may_skip && skip_true));

    always_comb begin
        next_q         = cyc_end ? RST_Q : q + 2'h1;
        next_cur_word  = cur_word;
        next_flush_cyc = flush_cyc;
        next_strobe    = 1'b0;
        next_fetch_s   = 1'b0;
        next_redir     = 1'b0;
        next_dec_r     = dec_r;
        next_op_r      = op_r;
        if (q == RST_Q) begin
            next_fetch_s = 1'b1;
        end
        if (cyc_end) begin
            next_strobe   = 1'b1;
            if (flush_cyc) begin
                // no-op slot: outputs show a nop, not the stale word
                next_dec_r         = '0;
                next_dec_r.bitmask = 8'h01;
                next_op_r      = IWD_OP_NOP;
                next_flush_cyc = 1'b0;
                next_cur_word  = fetch_word;
            end else begin
                next_dec_r = dec_w;
                next_op_r  = op_w;
                if (two_cyc) begin
                    next_flush_cyc = 1'b1;
                    next_redir     = 1'b1;
                    next_cur_word  = RST_WORD;
                end else begin
                    next_cur_word = fetch_word;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q         <= RST_Q;
            cur_word  <= RST_WORD;
            flush_cyc <= 1'b1;
            strobe    <= 1'b0;
            fetch_s   <= 1'b0;
            redir     <= 1'b0;
            dec_r     <= '0;
            op_r      <= IWD_OP_NOP;
        end else begin
            q         <= next_q;
            cur_word  <= next_cur_word;
            flush_cyc <= next_flush_cyc;
            strobe    <= next_strobe;
            fetch_s   <= next_fetch_s;
            redir     <= next_redir;
            dec_r     <= next_dec_r;
            op_r      <= next_op_r;
        end
    end

    assign exec_dec       = dec_r;
    assign exec_op        = op_r;
    assign exec_strobe    = strobe;
    assign exec_flush     = redir;
    assign fetch_strobe   = fetch_s;
    assign fetch_redirect = redir;
    assign q_phase        = q;

    a_phase_wrap: assert property (@(posedge clk_sys) disable iff (srst)
        strobe |-> ##4 strobe)
        else $error("instruction cycle not four periods");
    a_strobe_gap: assert property (@(posedge clk_sys) disable iff (srst)
        strobe |=> !strobe [*3])
        else $error("strobe repeats inside a cycle");
    a_flush_nop: assert property (@(posedge clk_sys) disable iff (srst)
        redir |-> ##4 (strobe && op_r == IWD_OP_NOP))
        else $error("second cycle not a no-op");
    a_redir_cause: assert property (@(posedge clk_sys) disable iff (srst)
        redir |-> strobe && (dec_r.pc_change || dec_r.may_skip))
        else $error("redirect without two-cycle instruction");
    a_dest_acc: assert property (@(posedge clk_sys) disable iff (srst)
        (strobe && op_r == IWD_OP_ALU) |-> (dec_r.to_acc != dec_r.to_file))
        else $error("byte op destination ambiguous");
    a_single_cyc: assert property (@(posedge clk_sys) disable iff (srst)
        (strobe && !dec_r.pc_change && !dec_r.may_skip && op_r != IWD_OP_NOP) |-> !redir)
        else $error("plain instruction took two cycles");
    a_bit_mask: assert property (@(posedge clk_sys) disable iff (srst)
        strobe |-> $onehot(dec_r.bitmask))
        else $error("bit select not one-hot");
    a_lit_width: assert property (@(posedge clk_sys) disable iff (srst)
        (strobe && !dec_r.lit_long) |-> (dec_r.literal[10:8] == 3'h0))
        else $error("short literal wider than eight bits");
    a_dont_care: assert property (@(posedge clk_sys) disable iff (srst)
        (strobe && op_r == IWD_OP_RETLW) |-> dec_r.to_acc)
        else $error("don't-care bits changed decode");

    c_goto:  cover property (@(posedge clk_sys) strobe && op_r == IWD_OP_GOTO);
    c_skip:  cover property (@(posedge clk_sys) redir && dec_r.may_skip);
    c_movwf: cover property (@(posedge clk_sys) strobe && op_r == IWD_OP_MOVWF);
    c_back:  cover property (@(posedge clk_sys) strobe && op_r == IWD_OP_ALU ##4 strobe && op_r == IWD_OP_ALU);
endmodule
`default_nettype wire

// file: iwd_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
module iwd_prog_mem
    import iwd_pkg::*;
(
    // clock
    input  wire logic        clk_sys,
    // decoder handshake
    input  wire logic        fetch_strobe,
    input  wire logic        fetch_redirect,
    input  wire logic [1:0]  q_phase,
    // word out
    output logic [13:0]      fetch_word
);
    logic [13:0] mem [0:255];
    logic [7:0]  pc = 8'h00;
    logic [7:0]  next_pc;
    logic [13:0] next_word;

    initial fetch_word = 14'h0000;

    always_comb begin
        next_pc = pc;
        if (fetch_redirect) begin
            // target one back, so the flushed prefetch is fetched again
            next_pc = pc - 8'h01;
        end else if (fetch_strobe) begin
            next_pc = pc + 8'h01;
        end
        // valid only for the sample phase; toggles elsewhere so a stale word is never caught
        next_word = (q_phase == 2'h2) ? mem[pc] : ~fetch_word;
    end

    always @(posedge clk_sys) begin
        pc <= next_pc;
        fetch_word <= next_word;
    end
endmodule
`default_nettype wire

// file: instruction_word_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module instruction_word_decoder_tb
    import iwd_pkg::*;
;
    // don't-care variants, reserved and legacy words placed on purpose
    localparam logic [13:0] CORNER [0:27] = '{14'h0000, 14'h0000, 14'h0060, 14'h0100, 14'h017F, 14'h0782,
        14'h0702, 14'h0082, 14'h3000, 14'h3300, 14'h3400, 14'h37FF, 14'h3B55, 14'h0062, 14'h0065,
        14'h0067, 14'h0008, 14'h0009, 14'h0063, 14'h0064, 14'h2000, 14'h2FFF, 14'h0B7F, 14'h1F80,
        14'h1000, 14'h3E00, 14'h3FFF, 14'h0001};
    logic        clk_sys = 1'h0;
    logic        srst = 1'h1;
    logic        skip_true = 1'h0;
    logic [13:0] fetch_word;
    logic        fetch_strobe;
    logic        fetch_redirect;
    logic        exec_strobe;
    logic        exec_flush;
    logic [1:0]  q_phase;
    iwd_dec_s    exec_dec;
    iwd_op_e     exec_op;
    logic [31:0] rs = 32'h0F3FB79C;
    logic [13:0] pend = 14'h0000;
    logic        pend_ok = 1'h0;
    int          num_errors = 0;
    int          comparisons = 0;
    int          strobes = 0;

    iwd_decoder #(.WIDTH(WORD_W)) iwd_decoder_i (.clk_sys(clk_sys), .srst(srst), .fetch_word(fetch_word),
        .fetch_strobe(fetch_strobe), .fetch_redirect(fetch_redirect), .skip_true(skip_true),
        .exec_dec(exec_dec), .exec_op(exec_op), .exec_strobe(exec_strobe), .exec_flush(exec_flush),
        .q_phase(q_phase));
    iwd_prog_mem iwd_prog_mem_i (.clk_sys(clk_sys), .fetch_strobe(fetch_strobe),
        .fetch_redirect(fetch_redirect), .q_phase(q_phase), .fetch_word(fetch_word));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic iwd_op_e ref_op(input logic [13:0] w);
        if (w[13:8] == 6'h00 && !w[7]) begin
            if (w[4:0] == 5'h00) return IWD_OP_NOP;
            case (w[6:0])
                7'h08: return IWD_OP_RETURN;
                7'h09: return IWD_OP_RETFIE;
                7'h62: return IWD_OP_OPTLOAD;
                7'h63: return IWD_OP_SLEEP;
                7'h64: return IWD_OP_CLRWDT;
                7'h65, 7'h66, 7'h67: return IWD_OP_TRISLOAD;
                default: return IWD_OP_RESERVED;
            endcase
        end
        case (w[13:12])
            2'h0: return (w[11:8] == 4'h0) ? IWD_OP_MOVWF : (w[11:8] == 4'h1) ? IWD_OP_CLR :
                (w[11:8] inside {4'hB, 4'hF}) ? IWD_OP_SKIPDEC : IWD_OP_ALU;
            2'h1: return w[11] ? (w[10] ? IWD_OP_BTFSS : IWD_OP_BTFSC) : (w[10] ? IWD_OP_BSF : IWD_OP_BCF);
            2'h2: return w[11] ? IWD_OP_GOTO : IWD_OP_CALL;
            default: return (w[11:8] == 4'hB) ? IWD_OP_RESERVED : (w[11:10] == 2'h1) ? IWD_OP_RETLW : IWD_OP_LITALU;
        endcase
    endfunction

    function automatic logic ref_file(input logic [13:0] w);
        return ref_op(w) == IWD_OP_MOVWF || (ref_op(w) inside {IWD_OP_ALU, IWD_OP_CLR, IWD_OP_SKIPDEC} && w[7]);
    endfunction

    function automatic logic ref_redir(input logic [13:0] w, input logic sk);
        iwd_op_e op;
        op = ref_op(w);
        if (op inside {IWD_OP_GOTO, IWD_OP_CALL, IWD_OP_RETURN, IWD_OP_RETFIE, IWD_OP_RETLW}) return 1'h1;
        if (op inside {IWD_OP_SKIPDEC, IWD_OP_BTFSC, IWD_OP_BTFSS} && sk) return 1'h1;
        return ref_file(w) && w[6:0] == 7'h02;
    endfunction

    task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] expd);
        comparisons++;
        if (seen !== expd) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, expd, seen);
        end
    endtask

    task automatic check_dec(input logic [13:0] w);
        iwd_op_e op;
        op = ref_op(w);
        chk("exec_op", 14'(exec_op), 14'(op));
        chk("reserved", 14'(exec_dec.reserved), 14'(op == IWD_OP_RESERVED));
        chk("legacy", 14'(exec_dec.legacy), 14'(op inside {IWD_OP_OPTLOAD, IWD_OP_TRISLOAD}));
        if (op inside {IWD_OP_ALU, IWD_OP_MOVWF, IWD_OP_CLR, IWD_OP_SKIPDEC}) begin
            chk("faddr", 14'(exec_dec.faddr), 14'(w[6:0]));
            chk("to_file", 14'(exec_dec.to_file), 14'(ref_file(w)));
            chk("to_acc", 14'(exec_dec.to_acc), 14'(!ref_file(w)));
        end
        if (w[13:12] == 2'h1) begin
            chk("bit_faddr", 14'(exec_dec.faddr), 14'(w[6:0]));
            chk("bitnum", 14'(exec_dec.bitnum), 14'(w[9:7]));
            chk("bitmask", 14'(exec_dec.bitmask), 14'(8'h01 << w[9:7]));
        end
        if (w[13:12] == 2'h2) begin
            chk("literal11", 14'(exec_dec.literal), 14'(w[10:0]));
            chk("lit_long", 14'(exec_dec.lit_long), 14'h0001);
        end
        if (op inside {IWD_OP_LITALU, IWD_OP_RETLW}) begin
            chk("literal8", 14'(exec_dec.literal[7:0]), 14'(w[7:0]));
            chk("lit_short", 14'(exec_dec.lit_long), 14'h0000);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always #2 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        rs <= xs(rs);
        skip_true <= rs[3];
    end

    // pre-edge values taken first, outputs looked at once the edge has settled
    always @(posedge clk_sys) begin
        logic [1:0]  was_q;
        logic [1:0]  nq;
        logic [13:0] w_in;
        logic        was_rst;
        logic        sk;
        logic        redir;
        was_q = q_phase;
        nq = q_phase + 2'h1;
        w_in = fetch_word;
        sk = skip_true;
        was_rst = srst;
        #1;
        if (was_rst) begin
            chk("rst_q", 14'(q_phase), 14'h0000);
            chk("rst_strobe", 14'(exec_strobe), 14'h0000);
            chk("rst_op", 14'(exec_op), 14'(IWD_OP_NOP));
            pend_ok = 1'h0;
        end else begin
            chk("q_phase", 14'(q_phase), 14'(nq));
            chk("fetch_strobe", 14'(fetch_strobe), 14'(q_phase == 2'h1));
            chk("exec_strobe", 14'(exec_strobe), 14'(was_q == 2'h3));
            if (was_q == 2'h3) begin
                strobes++;
                redir = 1'h0;
                if (pend_ok) begin
                    redir = ref_redir(pend, sk);
                    check_dec(pend);
                    chk("fetch_redirect", 14'(fetch_redirect), 14'(redir));
                    chk("exec_flush", 14'(exec_flush), 14'(redir));
                end else begin
                    chk("bubble_op", 14'(exec_op), 14'(IWD_OP_NOP));
                end
                pend = w_in;
                pend_ok = !redir;
            end
        end
    end

    initial begin
        for (int i = 0; i < 256; i++) begin
            rs = xs(rs);
            // file address 0x02 kept out of random words: bit ops on it have no agreed timing
            iwd_prog_mem_i.mem[i] = (i < 28) ? CORNER[i] : {rs[13:1], rs[0] | (rs[6:1] == 6'h01)};
        end
        repeat (8) @(posedge clk_sys);
        srst <= 1'h0;
        for (int k = 0; k < 3000 && strobes < 300; k++) @(posedge clk_sys);
        srst <= 1'h1;
        @(posedge clk_sys);
        srst <= 1'h0;
        for (int k = 0; k < 3000 && strobes < 600; k++) @(posedge clk_sys);
        finish_test();
    end

    // roughly four times the expected run length
    initial begin
        #40000;
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
